// File: dv/omc_host_model.sv
// host side model driving power, dtr and uart pins
`timescale 1ns/1ns
module omc_host_model (
  // clock
  input  wire logic core_clk,
  // pins toward the device
  output logic      power_control_input,
  output logic      dtr_n,
  output logic      uart_rx_char
);
  initial begin
    power_control_input = 1'b0;
    dtr_n = 1'b0;
    uart_rx_char = 1'b0;
  end
  task automatic toggle();
    @(posedge core_clk) power_control_input <= 1'b1;
    repeat (4) @(posedge core_clk);
    power_control_input <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic send_char();
    @(posedge core_clk) uart_rx_char <= 1'b1;
    repeat (4) @(posedge core_clk);
    uart_rx_char <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic set_dtr(input logic on);
    @(posedge core_clk) dtr_n <= !on;
  endtask
endmodule

// File: dv/omc_monitor.sv
// bound checker on the operating mode controller ports
`timescale 1ns/1ns
module omc_monitor
  import omc_pkg::*;
(
  // clock and reset
  input wire logic               core_clk,
  input wire logic               srst,
  // inputs watched
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic               supply_valid,
  input wire logic               periodic_timer_expired,
  input wire logic               edrx_paging_instant,
  input wire logic               rf_start,
  input wire logic               rf_busy,
  // outputs watched
  input wire omc_pkg::omc_mode_t mode,
  input wire logic               iface_enable,
  input wire logic               rtc_only
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // registered enables are decoded from next_mode, so they change in the same cycle as mode
  sequence held_s(omc_mode_t m);
    mode == m ##1 mode == m;
  endsequence
  sequence idle_entry_s;
    mode != st_idle ##1 mode == st_idle;
  endsequence
  supply_lost_a:
    assert property (!supply_valid [*5] |-> mode == st_not_powered)
    else $error("mode kept after supply loss");
  idle_dark_a:
    assert property (held_s(st_idle) |-> !iface_enable)
    else $error("interfaces on in idle");
  sleep_dark_a:
    assert property (held_s(st_deep_sleep) |-> rtc_only && !iface_enable)
    else $error("deep sleep not rtc only");
  active_live_a:
    assert property (held_s(st_active) |-> iface_enable)
    else $error("interfaces off in active");
  rf_connect_a:
    // command strobe lags the bus access by one edge
    assert property (mode == st_active && rf_start && supply_valid &&
      !$past(psel && penable && pwrite) |=> mode == st_connected)
    else $error("rf start did not connect");
  rf_release_a:
    assert property (mode == st_connected && !rf_busy && !rf_start &&
      supply_valid |=> mode == st_active)
    else $error("connected held without rf");
  sleep_wake_a:
    assert property (mode == st_deep_sleep && supply_valid &&
      (periodic_timer_expired || edrx_paging_instant) |=> mode == st_active)
    else $error("deep sleep missed wake");
  idle_source_a:
    assert property (idle_entry_s |-> $past(mode) == st_active)
    else $error("idle entered from other mode");
endmodule

bind omc_top omc_monitor omc_monitor_i (.core_clk(core_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite),
  .supply_valid(supply_valid), .rf_start(rf_start), .rf_busy(rf_busy),
  .periodic_timer_expired(periodic_timer_expired),
  .edrx_paging_instant(edrx_paging_instant), .mode(mode),
  .iface_enable(iface_enable), .rtc_only(rtc_only));

// File: dv/omc_top_tb.sv
// self-checking bench for the operating mode controller
`timescale 1ns/1ns
module omc_top_tb;
  import omc_pkg::*;
  localparam int N = 20;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic        supply_valid, rf_busy, other_busy, pw, dn, ux;
  logic        iface_enable, rtc_only, acc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  ev;
  omc_mode_t   mode;
  int          err_total, checks, seed, n_acc;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (acc === 1'b1) n_acc <= n_acc + 1;
  omc_top #(.INACT_CNT(longint'(N)), .INACT_W(30)) omc_top_i (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_valid(supply_valid),
    .power_control_input(pw), .dtr_n(dn), .uart_rx_char(ux),
    .periodic_timer_expired(ev[0]), .active_timer_expired(ev[1]),
    .edrx_paging_instant(ev[2]), .edrx_gap(ev[3]), .rf_start(ev[4]),
    .rf_terminated(ev[5]), .rf_busy(rf_busy), .other_busy(other_busy),
    .mode(mode), .iface_enable(iface_enable), .rtc_only(rtc_only),
    .uart_char_accept(acc));
  omc_host_model host (.core_clk(core_clk), .power_control_input(pw),
    .dtr_n(dn), .uart_rx_char(ux));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n, input omc_mode_t e, input string nm);
    repeat (n) @(posedge core_clk);
    #1 chk(nm, {29'h0, e}, {29'h0, mode});
    $display("test %s done", nm);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev <= 6'h00;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    seed = 7051;
    {psel, penable, pwrite, supply_valid, rf_busy, other_busy} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 6'h00;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    step(3, st_not_powered, "no_supply");
    supply_valid <= 1'b1;
    step(6, st_power_off, "supply_on");
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_reset", CTRL_RESET, rd);
    apb(1'b1, 8'h0c, $random(seed));
    chk("unmapped_err", 32'h1, {31'h0, er});
    host.toggle();
    step(6, st_active, "switch_on");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status_mode", {29'h0, st_active}, {29'h0, rd[2:0]});
    pulse(3);
    step(2, st_active, "gap_disabled");
    apb(1'b1, OFS_CTRL, {29'h0, LP_TIMER});
    other_busy <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_readback", {29'h0, LP_TIMER}, rd);
    apb(1'b1, OFS_CMD, 32'h2);
    step(N + 5, st_active, "busy_holds");
    other_busy <= 1'b0;
    step(N + 5, st_idle, "inactive_idle");
    chk("idle_iface", 32'h0, {31'h0, iface_enable});
    host.send_char();
    step(6, st_active, "char_wake");
    chk("first_char", 32'h0, n_acc);
    apb(1'b1, OFS_CTRL, {29'h0, LP_DTR});
    host.send_char();
    step(6, st_active, "char_ok");
    chk("second_char", 32'h1, n_acc);
    host.set_dtr(1'b0);
    step(6, st_idle, "dtr_off");
    host.set_dtr(1'b1);
    step(6, st_active, "dtr_on");
    pulse(4);
    rf_busy <= 1'b1;
    step(1, st_connected, "rf_start");
    repeat (1 + ($random(seed) & 7)) @(posedge core_clk);
    pulse(5);
    rf_busy <= 1'b0;
    step(2, st_active, "rf_end");
    pulse(4);
    step(0, st_connected, "rf_blip");
    step(2, st_active, "rf_idle");
    apb(1'b1, OFS_CTRL, 32'h80);
    apb(1'b1, OFS_CMD, 32'h2);
    step(N + 5, st_deep_sleep, "inactive_sleep");
    chk("rtc_only", 32'h1, {31'h0, rtc_only});
    apb(1'b1, OFS_CTRL, 32'h40);
    pulse(0);
    step(2, st_active, "periodic_wake");
    pulse(3);
    step(2, st_deep_sleep, "edrx_sleep");
    pulse(2);
    step(2, st_active, "paging_wake");
    apb(1'b1, OFS_CTRL, 32'h30);
    pulse(1);
    step(2, st_deep_sleep, "psm_sleep");
    host.toggle();
    step(6, st_active, "toggle_wake");
    apb(1'b1, OFS_CMD, 32'h1);
    step(2, st_power_off, "cmd_off");
    host.toggle();
    step(6, st_active, "on_again");
    host.toggle();
    step(6, st_power_off, "toggle_off");
    supply_valid <= 1'b0;
    step(6, st_not_powered, "supply_lost");
    tally_and_finish();
  end
endmodule

// File: logic/omc_pkg.sv
// package for the operating mode controller
package omc_pkg;
  // operating modes, exactly one held at a time
  typedef enum logic [2:0] {
    st_not_powered,
    st_power_off,
    st_deep_sleep,
    st_idle,
    st_active,
    st_connected
  } omc_mode_t;

  // low power setting values
  localparam logic [2:0] LP_DISABLED = 3'h0;
  localparam logic [2:0] LP_DTR      = 3'h3;
  localparam logic [2:0] LP_TIMER    = 3'h4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;

  // ctrl fields
  localparam int CTRL_LP_LSB   = 0;
  localparam int CTRL_LP_MSB   = 2;
  localparam int CTRL_PSM_EN   = 4;
  localparam int CTRL_PROF_OK  = 5;
  localparam int CTRL_EDRX_EN  = 6;
  localparam int CTRL_INACT_DS = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // command bits, write one to act
  localparam int CMD_POWEROFF = 0;
  localparam int CMD_ACTIVITY = 1;

  // mode output width
  localparam int MODE_W = 3;

  // inactivity time
  localparam int INACT_S     = 6;
  localparam longint CLK_HZ  = 125000000;
  localparam longint INACT_CYCLES = INACT_S * CLK_HZ;
endpackage

// File: logic/omc_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ns
module omc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// File: logic/omc_timer.sv
// restartable inactivity down counter
`timescale 1ns/1ns
module omc_timer #(
  parameter longint CYCLES = 750000000,
  parameter int     W      = 30
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // control
  input  wire logic restart,
  input  wire logic run,
  output logic      expired
);
  logic [W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (restart || !run) begin
      count   <= W'(CYCLES - 1);
      expired <= 1'b0;
    end else if (count == '0) begin
      expired <= 1'b1;
    end else begin
      count <= count - W'(1);
    end
  end
endmodule

// File: logic/omc_top.sv
// operating mode controller with apb register slave
// Operation
// - setting 4: active to idle after 6 s without command activity
// - setting 3: enter idle when dtr goes off
// - setting 4: first uart character in idle wakes, is discarded
// - setting 3: idle back to active when dtr goes on
// - power control switch-on moves power-off to active
// - deep-sleep wakes on periodic timer, paging instant or power toggle
// - active to deep-sleep on enabled triggers when nothing is pending
// - active to connected when rf data connection starts or is needed
// - connected back to active when rf idle or connection terminated
// - start not-powered; with valid supply wait in power-off
// - active mode: interfaces functional, commands accepted
// - deep-sleep: interfaces off; toggle or network timer wakes
// - power-off command or power toggle shuts active down to power-off
// - psm enabled with profile: enter deep-sleep when activity ends
// - deep-sleep between edrx cycles only when edrx sleep enabled
// - idle: powered, application interfaces disabled
// - deep-sleep: only the real-time clock runs
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module omc_top
  import omc_pkg::*;
#(
  parameter longint INACT_CNT = omc_pkg::INACT_CYCLES,
  parameter int     INACT_W   = 30
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pins from outside
  input  wire logic                     supply_valid,
  input  wire logic                     power_control_input,
  input  wire logic                     dtr_n,
  input  wire logic                     uart_rx_char,
  // events from logic on core_clk
  input  wire logic                     periodic_timer_expired,
  input  wire logic                     active_timer_expired,
  input  wire logic                     edrx_paging_instant,
  input  wire logic                     edrx_gap,
  input  wire logic                     rf_start,
  input  wire logic                     rf_busy,
  input  wire logic                     rf_terminated,
  input  wire logic                     other_busy,
  // mode and interface enables
  output omc_pkg::omc_mode_t            mode,
  output logic                          iface_enable,
  output logic                          rtc_only,
  output logic                          uart_char_accept
);
  import omc_pkg::*;

  logic        supply_s;
  logic        pwr_s;
  logic        dtr_n_s;
  logic        rx_s;
  logic        pwr_d;
  logic        rx_d;
  logic        pwr_toggle;
  logic        rx_edge;
  logic [31:0] ctrl;
  logic        cmd_poweroff;
  logic        cmd_activity;
  logic        inact_exp;
  logic        wake_pending;
  logic [2:0]  lp_set;
  logic        apb_acc;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_cmd;
  omc_mode_t   next_mode;

  // pins pass two flops first
  omc_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({supply_valid, power_control_input, dtr_n, uart_rx_char}),
    .sync_out ({supply_s, pwr_s, dtr_n_s, rx_s})
  );

  // edge detection on synchronised levels only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_d <= 1'b0;
      rx_d  <= 1'b0;
    end else begin
      pwr_d <= pwr_s;
      rx_d  <= rx_s;
    end
  end

  // one toggle is a released press; pulse timing is left to the pin owner
  assign pwr_toggle = pwr_d & ~pwr_s;
  assign rx_edge    = rx_s & ~rx_d;
  assign lp_set     = ctrl[CTRL_LP_MSB:CTRL_LP_LSB];

  // apb decode, zero wait states
  assign apb_acc    = psel & penable;
  assign pready     = 1'b1;
  assign hit_ctrl   = (paddr == OFS_CTRL);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_cmd    = (paddr == OFS_CMD);
  assign pslverr    = apb_acc & ~(hit_ctrl | hit_status | hit_cmd);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
    end else if (apb_acc && pwrite && hit_ctrl) begin
      ctrl <= pwdata;
    end
  end

  // command strobes, one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_poweroff <= 1'b0;
      cmd_activity <= 1'b0;
    end else begin
      cmd_poweroff <= apb_acc & pwrite & hit_cmd & pwdata[CMD_POWEROFF];
      cmd_activity <= apb_acc & pwrite & hit_cmd & pwdata[CMD_ACTIVITY];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= ctrl;
      end else if (hit_status) begin
        prdata <= {28'h0000000, wake_pending, mode};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // inactivity timer
  // restarts on any command activity; runs only in active mode
  omc_timer #(.CYCLES(INACT_CNT), .W(INACT_W)) u_inact (
    .core_clk (core_clk),
    .srst     (srst),
    .restart  (cmd_activity),
    .run      (mode == st_active),
    .expired  (inact_exp)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_pending <= 1'b0;
    end else if (mode == st_idle && rx_edge && lp_set == LP_TIMER) begin
      wake_pending <= 1'b1;
    end else if (mode == st_active) begin
      wake_pending <= 1'b0;
    end
  end

  // mode transitions
  always_comb begin
    next_mode = mode;
    case (mode)
      st_not_powered: begin
        if (supply_s) begin
          next_mode = st_power_off;
        end
      end
      st_power_off: begin
        if (pwr_toggle) begin
          next_mode = st_active;
        end
      end
      st_deep_sleep: begin
        if (pwr_toggle || periodic_timer_expired || edrx_paging_instant) begin
          next_mode = st_active;
        end
      end
      st_idle: begin
        if (lp_set == LP_DTR && !dtr_n_s) begin
          next_mode = st_active;
        end else if (wake_pending) begin
          next_mode = st_active;
        end else if (rf_start) begin
          next_mode = st_active;
        end
      end
      st_active: begin
        if (cmd_poweroff || pwr_toggle) begin
          next_mode = st_power_off;
        end else if (rf_start || rf_busy) begin
          next_mode = st_connected;
        end else if (!other_busy) begin
          if ((ctrl[CTRL_PSM_EN] && ctrl[CTRL_PROF_OK] &&
               active_timer_expired) ||
              (ctrl[CTRL_EDRX_EN] && edrx_gap) ||
              (ctrl[CTRL_INACT_DS] && inact_exp)) begin
            next_mode = st_deep_sleep;
          end else if ((lp_set == LP_TIMER && inact_exp) ||
                       (lp_set == LP_DTR && dtr_n_s)) begin
            next_mode = st_idle;
          end
        end
      end
      st_connected: begin
        if (rf_terminated || !rf_busy) begin
          next_mode = st_active;
        end
      end
      default: begin
        next_mode = st_not_powered;
      end
    endcase
    // supply loss overrides all
    if (!supply_s) begin
      next_mode = st_not_powered;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= st_not_powered;
    end else begin
      mode <= next_mode;
    end
  end

  // interfaces only in active or connected
  always_ff @(posedge core_clk) begin
    if (srst) begin
      iface_enable     <= 1'b0;
      rtc_only         <= 1'b0;
      uart_char_accept <= 1'b0;
    end else begin
      iface_enable     <= (next_mode == st_active) ||
                          (next_mode == st_connected);
      rtc_only         <= (next_mode == st_deep_sleep);
      uart_char_accept <= rx_edge &&
                          (mode == st_active || mode == st_connected);
    end
  end
endmodule
